// >>> hdl/rwp_top.sv
// reset sequencer with watchdog period register and axi4-lite slave
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rwp_params.svh"
// Operation
// - period register upper five bits read zero
// - period code selects 2^(8+code) watchdog clocks
// - power-on clears program counter
// - power-on sets port data, direction ones
// - reset delay after pin release
// - pin reset clears program counter, restarts
// - pin reset keeps some registers unchanged
// - low-voltage reset enabled, threshold by config
// - low supply must persist qualification time
// - low-voltage reset equals pin reset
// - running watchdog timeout resets, sets timeout
// - sleep timeout clears pc, sp, sets timeout
// - start-up timer 2 rc, 128 crystal
// - five reset sources accepted
// - flags cleared on power-on, kept on pin
// - powerdown set by halt, cleared by clear
module rwp_top #(
  parameter int unsigned RESET_DELAY_CYC = `RWP_RESET_DELAY_CYC
) (
  // clocking
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // reset sources
  input wire logic ext_reset_pin_b,
  input wire logic supply_low,
  input wire logic wdt_overflow,
  input wire logic sleeping,
  input wire logic halt_exec,
  input wire logic wdt_clear_exec,
  // core reset controls
  output logic core_run,
  output logic pc_clear,
  output logic sp_clear,
  output logic full_reset,
  output logic port_preset,
  output logic [2:0] period_select,
  output logic [15:0] wdt_period_len,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic [1:0] lv_threshold,
  output logic irq,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import rwp_pkg::*;

  typedef struct packed {
    rwp_state_t state;
    rwp_src_t last_src;
    logic por_done;
    logic [2:0] period;
    logic lv_en;
    logic xtal;
    logic [1:0] lv_thr;
    logic to_flag;
    logic pd_flag;
    logic [15:0] lv_cnt;
    logic [7:0] sst_cnt;
    logic pc_clr;
    logic sp_clr;
    logic full;
    logic ports;
    logic [3:0] istat;
    logic [3:0] imask;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rwp_st_t;

  rwp_st_t st, next_st;
  logic pin_sync;
  logic delay_done;
  logic delay_load;
  logic lv_qual;
  logic pin_low;

  // decode of a register address, reused by both channels
  function automatic logic rwp_mapped(input logic [7:0] a);
    rwp_mapped = (a == `RWP_OFF_PERIOD) || (a == `RWP_OFF_STATUS) ||
                 (a == `RWP_OFF_CTRL) || (a == `RWP_OFF_IRQ_STAT) ||
                 (a == `RWP_OFF_IRQ_MASK);
  endfunction : rwp_mapped

  // pin filtered through two flops so a glitch cannot release reset
  rwp_sync u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .din(ext_reset_pin_b),
    .dout(pin_sync)
  );

  // reset delay counter, long count kept out of the struct
  rwp_counter u_delay (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(delay_load),
    .load_val(32'(RESET_DELAY_CYC)),
    .done(delay_done)
  );

  assign pin_low = !pin_sync;
  assign lv_qual = st.lv_en && supply_low && (st.lv_cnt >= 16'(`RWP_LV_QUAL_CYC));
  // reload on every hold cycle: a running timeout enters hold with the pin
  // high, and must still serve the whole delay from a fresh count
  assign delay_load = (st.state == RWP_HOLD);

  always_comb begin
    logic [3:0] ev;
    logic [31:0] wd;
    ev = 4'h0;
    wd = 32'h0;
    next_st = st;
    next_st.pc_clr = 1'b0;
    next_st.sp_clr = 1'b0;
    // low-supply persistence counter, short dips restart it
    if (st.lv_en && supply_low) begin
      if (st.lv_cnt < 16'(`RWP_LV_QUAL_CYC)) next_st.lv_cnt = st.lv_cnt + 16'h1;
    end else begin
      next_st.lv_cnt = 16'h0;
    end
    // set by halt, cleared by clear instruction; events below win
    if (wdt_clear_exec) next_st.pd_flag = 1'b0;
    if (halt_exec && st.state == RWP_RUN) next_st.pd_flag = 1'b1;
    // sequencer
    case (st.state)
      RWP_HOLD: begin
        next_st.full = 1'b1;
        next_st.pc_clr = 1'b1;
        next_st.sp_clr = 1'b1;
        if (!pin_low && !lv_qual) begin
          next_st.state = RWP_DELAY;
        end
      end
      RWP_DELAY: begin
        if (pin_low || lv_qual) begin
          next_st.state = RWP_HOLD;
        end else if (delay_done) begin
          next_st.state = RWP_START;
          next_st.por_done = 1'b1;
          next_st.ports = 1'b0;
          next_st.sst_cnt = st.xtal ? `RWP_SST_XTAL_CYC : `RWP_SST_RC_CYC;
        end
      end
      RWP_START: begin
        next_st.full = 1'b0;
        if (st.sst_cnt <= 8'h1) next_st.state = RWP_RUN;
        else next_st.sst_cnt = st.sst_cnt - 8'h1;
      end
      RWP_RUN: begin
        if (pin_low || lv_qual) begin
          next_st.state = RWP_HOLD;
          next_st.last_src = pin_low ? RWP_SRC_PIN : RWP_SRC_LV; // flags kept
          ev[pin_low ? `RWP_EV_PIN : `RWP_EV_LV] = 1'b1;
        end else if (wdt_overflow && !sleeping) begin
          next_st.state = RWP_HOLD;
          next_st.last_src = RWP_SRC_WDT_RUN;
          next_st.to_flag = 1'b1;
          next_st.period = `RWP_PERIOD_RST;
          ev[`RWP_EV_WDT] = 1'b1;
        end else if (wdt_overflow && sleeping) begin
          next_st.state = RWP_START;
          next_st.sst_cnt = st.xtal ? `RWP_SST_XTAL_CYC : `RWP_SST_RC_CYC;
          next_st.last_src = RWP_SRC_WDT_SLEEP;
          next_st.pc_clr = 1'b1;
          next_st.sp_clr = 1'b1;
          next_st.to_flag = 1'b1;
          next_st.pd_flag = 1'b1;
          ev[`RWP_EV_WAKE] = 1'b1;
        end
      end
      default: next_st.state = RWP_HOLD;
    endcase
    // full reset values for pin, low-voltage and running timeout, applied on
    // the entering edge so the core sees them in the cycle it stops
    if (next_st.state == RWP_HOLD && st.por_done) begin
      next_st.full = 1'b1;
      next_st.pc_clr = 1'b1;
      next_st.sp_clr = 1'b1;
      next_st.period = `RWP_PERIOD_RST;
      next_st.ports = 1'b1;
    end
    // write channel: take address and data in either order
    if (s_awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_awaddr;
    end
    if (s_wvalid && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_wdata;
      next_st.w_strb = s_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      wd = st.w_data;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = rwp_mapped(st.aw_addr) ? 2'h0 : 2'h2;
      if (st.w_strb[0]) begin
        case (st.aw_addr)
          `RWP_OFF_PERIOD: next_st.period = wd[2:0];
          `RWP_OFF_CTRL: begin
            next_st.lv_en = wd[`RWP_CT_LV_EN];
            next_st.xtal = wd[`RWP_CT_XTAL];
            next_st.lv_thr = wd[`RWP_CT_LV_THR_LSB +: `RWP_CT_LV_THR_W];
          end
          `RWP_OFF_IRQ_STAT: next_st.istat = st.istat & ~wd[3:0];
          `RWP_OFF_IRQ_MASK: next_st.imask = wd[3:0];
          default: ;
        endcase
      end
    end
    if (st.bvalid && s_bready) next_st.bvalid = 1'b0;
    // new events set after any software clear, so set wins
    next_st.istat = next_st.istat | ev;
    // read channel
    if (s_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = rwp_mapped(s_araddr) ? 2'h0 : 2'h2;
      case (s_araddr)
        `RWP_OFF_PERIOD: next_st.rdata = {29'h0, st.period};
        // status also tells software which source caused the last reset
        `RWP_OFF_STATUS:
          next_st.rdata = {26'h0, st.last_src, st.state == RWP_RUN, st.pd_flag, st.to_flag};
        `RWP_OFF_CTRL: next_st.rdata = {26'h0, st.lv_thr, 2'h0, st.xtal, st.lv_en};
        `RWP_OFF_IRQ_STAT: next_st.rdata = {28'h0, st.istat};
        `RWP_OFF_IRQ_MASK: next_st.rdata = {28'h0, st.imask};
        default: next_st.rdata = 32'h0;
      endcase
    end else if (st.rvalid && s_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // power-on: flags clear, ports high, period all ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= RWP_HOLD;
      st.last_src <= RWP_SRC_POR;
      st.period <= `RWP_PERIOD_RST;
      st.ports <= 1'b1;
      st.full <= 1'b1;
      st.pc_clr <= 1'b1;
      st.sp_clr <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs
  assign core_run = (st.state == RWP_RUN);
  assign pc_clear = st.pc_clr;
  assign sp_clear = st.sp_clr;
  assign full_reset = st.full;
  assign port_preset = st.ports;
  assign period_select = st.period;
  assign wdt_period_len = 16'h100 << st.period;
  assign timeout_flag = st.to_flag;
  assign powerdown_flag = st.pd_flag;
  assign lv_threshold = st.lv_thr;
  assign irq = |(st.istat & st.imask);
  assign s_awready = !st.aw_got;
  assign s_wready = !st.w_got;
  assign s_bvalid = st.bvalid;
  assign s_bresp = st.bresp;
  assign s_arready = !st.rvalid;
  assign s_rvalid = st.rvalid;
  assign s_rdata = st.rdata;
  assign s_rresp = st.rresp;

  // checks
  period_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_rvalid && $past(s_araddr) == `RWP_OFF_PERIOD && $past(s_arvalid) && $rose(s_rvalid)
    |-> s_rdata[31:3] == 29'h0) else $error("period upper bits not zero");
  period_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    wdt_period_len == (16'h100 << period_select)) else $error("period length wrong");
  pin_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && !pin_sync |=> !core_run && pc_clear) else $error("pin reset missed");
  wdt_run_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && pin_sync && !lv_qual && wdt_overflow && !sleeping
    |=> timeout_flag && full_reset) else $error("running timeout wrong");
  wdt_sleep_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && pin_sync && !lv_qual && wdt_overflow && sleeping
    |=> timeout_flag && powerdown_flag && pc_clear && sp_clear && !full_reset)
    else $error("sleep timeout wrong");
  lv_short_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !supply_low |=> !lv_qual)
    else $error("short low supply qualified");
  start_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && st.state == RWP_START && st.sst_cnt > 8'h1 |=> !core_run)
    else $error("start-up timer short");
  halt_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && halt_exec && !wdt_overflow |=> powerdown_flag)
    else $error("powerdown not set");
  delay_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.state == RWP_DELAY && !delay_done |=> !core_run) else $error("delay skipped");
  // a running timeout must serve the delay too, not fall straight through
  wdt_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && st.state == RWP_HOLD && !pin_low && !lv_qual |=> !delay_done)
    else $error("reset delay skipped");
  pin_ports_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && !pin_sync |=> port_preset && full_reset)
    else $error("ports not preset");
  // sleep wake keeps everything but pc, sp, flags, last source and wake event
  sleep_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && pin_sync && !lv_qual && wdt_overflow && sleeping && !st.w_got
    |=> period_select == $past(period_select)) else $error("sleep wake touched period");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_run && !pin_sync |=> st.istat[`RWP_EV_PIN]) else $error("pin event lost");
  run_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(core_run));
  sleep_c: cover property (@(posedge clk) disable iff (!rst_b)
    core_run && wdt_overflow && sleeping);
  wdt_run_c: cover property (@(posedge clk) disable iff (!rst_b)
    core_run && wdt_overflow && !sleeping);
  pin_c: cover property (@(posedge clk) disable iff (!rst_b) core_run && !pin_sync);
  lv_c: cover property (@(posedge clk) disable iff (!rst_b) lv_qual);
endmodule : rwp_top

// >>> hdl/rwp_params.svh
// constants for the reset sequencer and watchdog period register
`ifndef RWP_PARAMS_SVH
`define RWP_PARAMS_SVH
// register byte offsets (chosen, none printed)
`define RWP_OFF_PERIOD 8'h00
`define RWP_OFF_STATUS 8'h04
`define RWP_OFF_CTRL 8'h08
`define RWP_OFF_IRQ_STAT 8'h0c
`define RWP_OFF_IRQ_MASK 8'h10
// period select field
`define RWP_PERIOD_W 3
`define RWP_PERIOD_RST 3'h7
// status bits
`define RWP_ST_TIMEOUT 0
`define RWP_ST_POWERDOWN 1
`define RWP_ST_RUN 2
// control bits
`define RWP_CT_LV_EN 0
`define RWP_CT_XTAL 1
`define RWP_CT_LV_THR_LSB 4
`define RWP_CT_LV_THR_W 2
// interrupt event bits
`define RWP_EV_PIN 0
`define RWP_EV_LV 1
`define RWP_EV_WDT 2
`define RWP_EV_WAKE 3
`define RWP_EV_W 4
// timing
`define RWP_CLK_NS 8
`define RWP_RESET_DELAY_MS 50
`define RWP_RESET_DELAY_CYC ((`RWP_RESET_DELAY_MS * 1000000) / `RWP_CLK_NS)
`define RWP_SST_RC_CYC 8'd2
`define RWP_SST_XTAL_CYC 8'd128
`define RWP_LV_QUAL_NS 1000
`define RWP_LV_QUAL_CYC ((`RWP_LV_QUAL_NS + `RWP_CLK_NS - 1) / `RWP_CLK_NS)
`endif

// >>> hdl/rwp_pkg.sv
// types for the reset sequencer
package rwp_pkg;
  typedef enum logic [2:0] {
    RWP_HOLD = 3'b000,
    RWP_DELAY = 3'b001,
    RWP_START = 3'b010,
    RWP_RUN = 3'b011
  } rwp_state_t;
  typedef enum logic [2:0] {
    RWP_SRC_NONE = 3'b000,
    RWP_SRC_POR = 3'b001,
    RWP_SRC_PIN = 3'b010,
    RWP_SRC_LV = 3'b011,
    RWP_SRC_WDT_RUN = 3'b100,
    RWP_SRC_WDT_SLEEP = 3'b101
  } rwp_src_t;
endpackage : rwp_pkg

// >>> hdl/rwp_sync.sv
// two-stage synchroniser with glitch filter on the second stage
`timescale 1ns/1ps
module rwp_sync (
  // clocking
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // level
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rwp_sync_st_t;
  rwp_sync_st_t st, next_st;
  // s1 only feeds s2; output is high only while s2 and s3 are both high
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  assign dout = st.s2 & st.s3;
endmodule : rwp_sync

// >>> hdl/rwp_counter.sv
// loadable down counter with done flag
`timescale 1ns/1ps
module rwp_counter (
  // clocking
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // control
  input wire logic load,
  input wire logic [31:0] load_val,
  output logic done
);
  typedef struct packed {
    logic [31:0] cnt;
  } rwp_cnt_st_t;
  rwp_cnt_st_t st, next_st;
  // load wins over counting
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = load_val;
    end else if (st.cnt != 32'h0) begin
      next_st.cnt = st.cnt - 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  assign done = (st.cnt == 32'h0) && !load;
endmodule : rwp_counter

// >>> tb/rwp_partner.sv
// model of the external reset network and the supply monitor
`timescale 1ns/1ps
module rwp_partner (
  // clocking
  input wire logic clk,
  input wire logic rst_b,
  // commands from the bench
  input wire logic pin_hold,
  input wire logic dip,
  // far side levels
  output logic ext_reset_pin_b,
  output logic supply_low
);
  logic [3:0] rc;
  // rc network keeps the pin low a while past power-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rc <= 4'h0;
    else if (rc != 4'hf) rc <= rc + 4'h1;
  end
  // a switch may pull the pin low at any time
  assign ext_reset_pin_b = (rc == 4'hf) && !pin_hold;
  // monitor output is a plain level, no filtering here
  assign supply_low = dip;
endmodule : rwp_partner

// >>> tb/reset_and_wdt_period_control_tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "rwp_params.svh"
module reset_and_wdt_period_control_tb;
  import rwp_pkg::*;
  localparam int DLY = 20;
  logic clk = 0, rst_b = 0, pin_hold = 0, dip = 0;
  logic ov = 0, slp = 0, halt = 0, wclr = 0, ext_b, sup;
  logic run, pcc, spc, full, pre, to_f, pd_f, irq;
  logic [2:0] psel;
  logic [15:0] plen;
  logic [1:0] thr, bresp, rresp;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  int failures = 0, check_count = 0, n;
  logic [33:0] exp_q[$];
  logic [33:0] e;

  // 125 mhz clock
  always #4 clk = ~clk;

  rwp_partner rwp_partner_i (.clk(clk), .rst_b(rst_b), .pin_hold(pin_hold), .dip(dip),
    .ext_reset_pin_b(ext_b), .supply_low(sup));

  rwp_top #(.RESET_DELAY_CYC(DLY)) rwp_top_i (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
    .ext_reset_pin_b(ext_b), .supply_low(sup), .wdt_overflow(ov), .sleeping(slp),
    .halt_exec(halt), .wdt_clear_exec(wclr), .core_run(run), .pc_clear(pcc),
    .sp_clear(spc), .full_reset(full), .port_preset(pre), .period_select(psel),
    .wdt_period_len(plen), .timeout_flag(to_f), .powerdown_flag(pd_f),
    .lv_threshold(thr), .irq(irq), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));

  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task hang;
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report;
  endtask : hang

  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) begin
      e = exp_q.size() ? exp_q.pop_front() : 34'h3ffffffff;
      chk({30'h0, rresp}, {30'h0, e[33:32]});
      chk(rdata, e[31:0]);
    end
  end

  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50 && !(bvalid && bready); n++) begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
    end
    if (n == 50) hang;
    chk({30'h0, bresp}, 32'h0);
    bready <= 0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50 && !(rvalid && rready); n++) begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 0;
    end
    if (n == 50) hang;
    rready <= 0;
    @(posedge clk);
  endtask : rd

  // bounded wait for the run level, counting cycles
  task wt(input logic v, output int c);
    for (c = 0; c < 400 && run !== v; c++) @(negedge clk);
    if (c == 400) hang;
    @(posedge clk);
  endtask : wt

  // pin reset, then time the way back to run
  task pin_reset(input int startup_timer);
    int c;
    pin_hold <= 1;
    wt(0, c);
    chk({pcc, full, pre}, 3'b111);
    repeat (5) @(posedge clk);
    pin_hold <= 0;
    wt(1, c);
    chk(c >= DLY + startup_timer && c <= DLY + startup_timer + 12, 1);
  endtask : pin_reset

  initial begin
    int c;
    void'($urandom(32'h2769));
    repeat (16) @(posedge clk);
    chk({run, full, pcc, spc, pre, psel, to_f, pd_f}, 10'b0111111100);
    rst_b <= 1;
    wt(1, c);
    chk(c >= DLY + 2, 1);
    $display("test power-on done");
    for (int k = 0; k < 8; k++) begin
      wr(`RWP_OFF_PERIOD, ($urandom() & 32'hfffffff8) | k);
      rd(`RWP_OFF_PERIOD, k, 2'b00);
      chk(plen, 32'h100 << k);
    end
    rd(8'h40, 32'h0, 2'b10);
    $display("test period done");
    // watchdog bite while running
    ov <= 1;
    @(posedge clk);
    ov <= 0;
    wt(0, c);
    chk({to_f, pd_f, full}, 3'b101);
    wt(1, c);
    rd(`RWP_OFF_STATUS, {26'h0, RWP_SRC_WDT_RUN, 3'b101}, 2'b00);
    wr(`RWP_OFF_IRQ_STAT, 32'hf);
    pin_reset(2);
    chk(to_f, 1);
    wr(`RWP_OFF_IRQ_MASK, 32'h1);
    chk(irq, 1);
    rd(`RWP_OFF_IRQ_STAT, 32'h1, 2'b00);
    wr(`RWP_OFF_IRQ_STAT, 32'h1);
    chk(irq, 0);
    $display("test pin done");
    // sleep, then a watchdog wake
    halt <= 1;
    slp <= 1;
    @(posedge clk);
    halt <= 0;
    repeat (2) @(posedge clk);
    chk(pd_f, 1);
    ov <= 1;
    @(posedge clk);
    ov <= 0;
    for (n = 0; n < 40 && pcc !== 1; n++) @(negedge clk);
    if (n == 40) hang;
    chk({pcc, spc, full, to_f, pd_f}, 5'b11011);
    @(posedge clk);
    slp <= 0;
    wt(1, c);
    wclr <= 1;
    @(posedge clk);
    wclr <= 0;
    repeat (2) @(posedge clk);
    chk(pd_f, 0);
    $display("test sleep done");
    wr(`RWP_OFF_CTRL, 32'h2);
    pin_reset(128);
    $display("test crystal done");
    // low supply ignored while disabled, then short and long dips
    for (int k = 0; k < 3; k++) begin
      if (k == 1) wr(`RWP_OFF_CTRL, 32'h21);
      c = k == 1 ? 20 + $urandom() % 80 : 200;
      dip <= 1;
      n = 0;
      repeat (c) begin
        @(negedge clk);
        if (run !== 1) n++;
      end
      @(posedge clk);
      dip <= 0;
      @(posedge clk);
      chk(n != 0, k == 2);
    end
    chk(thr, 2'b10);
    wt(1, c);
    $display("test low supply done");
    chk(exp_q.size(), 0);
    final_report;
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    hang;
  end
endmodule : reset_and_wdt_period_control_tb
